// ===== aux_diag_pkg.sv
// Overview of operation
// - General control is 8-bit write-only, written at port 20H or 21H.
// - General control bits 0-3 and 7 are ignored; only bits 4-6 act.
// - Bits 4-6 drive three diagnostic LEDs as a code; 0 lights an LED.
// - Address inversion flag follows address bit 0: 21H sets, 20H clears.
// - Flag low inverts CPU address line 15, moving private RAM to 8000H.
// - Flag is held low while the auxiliary processor is in reset.
// - Read of port 21H returns the flag in bit 0.
// - Drive status is 8-bit read-only, read at port 40H.
// - Status bits 1:0 echo the last written drive select code.
// - Status bit 2 shows the live track-greater-than-43 line.
// - Status bits 3 and 4 show the active-low motor lines.
// - Status bit 5 shows the side select line; zero for single-sided use.
// - Status bit 6 shows the floppy chip interrupt request.
// - Status bit 7 shows the floppy chip data request.
// - Drive control is 8-bit write-only, written at port 40H.
// - Control bits 1:0 pick drive A-D; exactly one drive selected.
// - Control bit 2 forces drive-ready into the floppy chip.
// - Control bits 3 and 4 turn on the first and second unit motors.
// - Control bit 5 drives the active-low side line; software writes 0 single-sided.
// - Motor, select and side outputs go to drives and to the status.
// - Control bits 7:6 with inner-track form precompensation table address.
// - Inner-track indication is 0 for tracks 0-43, 1 for 44-79.
package aux_diag_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Port addresses
    localparam logic [7:0] PORT_GEN_CLR    = 8'h20;
    localparam logic [7:0] PORT_GEN_SET    = 8'h21;
    localparam logic [7:0] PORT_DRIVE      = 8'h40;

    ////////////////////////////////////////////////////////////////////////////
    // General control fields
    localparam int         GEN_LED_LSB     = 4;
    localparam int         GEN_LED_MSB     = 6;
    localparam logic [2:0] GEN_LED_RESET   = 3'h7;
    localparam logic       GEN_FLAG_RESET  = 1'b0;
    localparam int         GEN_STS_FLAG    = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Drive control fields
    localparam int         DRV_SEL_LSB     = 0;
    localparam int         DRV_SEL_MSB     = 1;
    localparam int         DRV_READY_BIT   = 2;
    localparam int         DRV_MOTOR0_BIT  = 3;
    localparam int         DRV_MOTOR1_BIT  = 4;
    localparam int         DRV_SIDE_BIT    = 5;
    localparam int         DRV_PC_LSB      = 6;
    localparam int         DRV_PC_MSB      = 7;
    localparam logic [7:0] DRV_CTRL_RESET  = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Drive status fields
    localparam int         STS_SEL_LSB     = 0;
    localparam int         STS_SEL_MSB     = 1;
    localparam int         STS_INNER_BIT   = 2;
    localparam int         STS_MOTOR0_BIT  = 3;
    localparam int         STS_MOTOR1_BIT  = 4;
    localparam int         STS_SIDE_BIT    = 5;
    localparam int         STS_IRQ_BIT     = 6;
    localparam int         STS_DRQ_BIT     = 7;
    localparam logic [7:0] RDATA_RESET     = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Drive select decode
    function automatic logic [3:0] drive_onehot(input logic [1:0] sel);
        drive_onehot = 4'h1 << sel;
    endfunction : drive_onehot

endpackage : aux_diag_pkg

// ===== gen_diag_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module gen_diag_ctrl
    import aux_diag_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_cpu_reset,
    input  wire logic       i_wr_en,
    input  wire logic       i_addr0,
    input  wire logic [7:0] i_wdata,
    output logic      [2:0] o_diag_led_n,
    output logic            o_addr_invert_flag_n
);

    typedef struct packed {
        logic [2:0] led_n;
        logic       flag;
    } gen_state_s;

    gen_state_s state;
    gen_state_s next_state;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_state = state;
        if (i_wr_en) begin
            next_state.led_n = i_wdata[GEN_LED_MSB:GEN_LED_LSB];
            next_state.flag  = i_addr0;
        end
        if (i_cpu_reset) begin
            next_state.flag = GEN_FLAG_RESET;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state.led_n <= GEN_LED_RESET;
            state.flag  <= GEN_FLAG_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign o_diag_led_n         = state.led_n;
    assign o_addr_invert_flag_n = state.flag;

endmodule : gen_diag_ctrl
`default_nettype wire

// ===== drive_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module drive_ctrl
    import aux_diag_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_wr_en,
    input  wire logic [7:0] i_wdata,
    output logic      [1:0] o_drive_select,
    output logic            o_force_ready,
    output logic            o_motor0_on_n,
    output logic            o_motor1_on_n,
    output logic            o_side_sel_n,
    output logic      [1:0] o_precomp_code
);

    typedef struct packed {
        logic [7:0] ctrl;
    } drive_state_s;

    drive_state_s state;
    drive_state_s next_state;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_state = state;
        if (i_wr_en) begin
            next_state.ctrl = i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state.ctrl <= DRV_CTRL_RESET;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Field outputs
    assign o_drive_select = state.ctrl[DRV_SEL_MSB:DRV_SEL_LSB];
    assign o_force_ready  = state.ctrl[DRV_READY_BIT];
    assign o_motor0_on_n  = ~state.ctrl[DRV_MOTOR0_BIT];
    assign o_motor1_on_n  = ~state.ctrl[DRV_MOTOR1_BIT];
    assign o_side_sel_n   = state.ctrl[DRV_SIDE_BIT];
    assign o_precomp_code = state.ctrl[DRV_PC_MSB:DRV_PC_LSB];

endmodule : drive_ctrl
`default_nettype wire

// ===== aux_cpu_diag_and_drive_regs.sv
`timescale 1ns/1ps
`default_nettype none
module aux_cpu_diag_and_drive_regs
    import aux_diag_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_cpu_reset,
    input  wire logic [7:0] i_io_addr,
    input  wire logic       i_io_wr,
    input  wire logic       i_io_rd,
    input  wire logic [7:0] i_io_wdata,
    output logic      [7:0] o_io_rdata,
    output logic            o_io_rd_valid,
    input  wire logic       i_cpu_a15,
    output logic            o_mem_a15,
    output logic            o_addr_invert_flag_n,
    output logic            o_diag_led_bit0_n,
    output logic            o_diag_led_bit1_n,
    output logic            o_diag_led_bit2_n,
    input  wire logic       i_inner_track_n,
    input  wire logic       i_fc_irq,
    input  wire logic       i_fc_drq,
    output logic      [1:0] o_drive_select,
    output logic      [3:0] o_drive_sel_onehot,
    output logic            o_force_ready,
    output logic            o_motor0_on_n,
    output logic            o_motor1_on_n,
    output logic            o_side_sel_n,
    output logic      [2:0] o_precomp_addr
);

    typedef struct packed {
        logic [7:0] rdata;
        logic       rd_valid;
    } bus_state_s;

    bus_state_s state;
    bus_state_s next_state;

    logic       gen_wr;
    logic       drive_wr;
    logic [2:0] led_n;
    logic [1:0] precomp_code;
    logic [7:0] drive_status;

    ////////////////////////////////////////////////////////////////////////////
    // Write decode
    always_comb begin
        gen_wr   = 1'b0;
        drive_wr = 1'b0;
        if (i_io_wr && (i_io_addr == PORT_GEN_CLR || i_io_addr == PORT_GEN_SET)) begin
            gen_wr = 1'b1;
        end else if (i_io_wr && i_io_addr == PORT_DRIVE) begin
            drive_wr = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register blocks
    gen_diag_ctrl u_gen (
        .i_clk                (i_clk),
        .i_rst                (i_rst),
        .i_cpu_reset          (i_cpu_reset),
        .i_wr_en              (gen_wr),
        .i_addr0              (i_io_addr[0]),
        .i_wdata              (i_io_wdata),
        .o_diag_led_n         (led_n),
        .o_addr_invert_flag_n (o_addr_invert_flag_n)
    );

    drive_ctrl u_drive (
        .i_clk          (i_clk),
        .i_rst          (i_rst),
        .i_wr_en        (drive_wr),
        .i_wdata        (i_io_wdata),
        .o_drive_select (o_drive_select),
        .o_force_ready  (o_force_ready),
        .o_motor0_on_n  (o_motor0_on_n),
        .o_motor1_on_n  (o_motor1_on_n),
        .o_side_sel_n   (o_side_sel_n),
        .o_precomp_code (precomp_code)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs to drives, LEDs and memory
    assign o_diag_led_bit0_n  = led_n[0];
    assign o_diag_led_bit1_n  = led_n[1];
    assign o_diag_led_bit2_n  = led_n[2];
    assign o_mem_a15          = i_cpu_a15 ^ ~o_addr_invert_flag_n;
    assign o_drive_sel_onehot = drive_onehot(o_drive_select);
    assign o_precomp_addr     = {~i_inner_track_n, precomp_code};

    ////////////////////////////////////////////////////////////////////////////
    // Drive status assembly
    always_comb begin
        drive_status                            = 8'h00;
        drive_status[STS_SEL_MSB:STS_SEL_LSB]   = o_drive_select;
        drive_status[STS_INNER_BIT]             = i_inner_track_n;
        drive_status[STS_MOTOR0_BIT]            = o_motor0_on_n;
        drive_status[STS_MOTOR1_BIT]            = o_motor1_on_n;
        drive_status[STS_SIDE_BIT]              = o_side_sel_n;
        drive_status[STS_IRQ_BIT]               = i_fc_irq;
        drive_status[STS_DRQ_BIT]               = i_fc_drq;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path
    always_comb begin
        next_state          = state;
        next_state.rd_valid = i_io_rd;
        if (i_io_rd) begin
            if (i_io_addr == PORT_GEN_SET) begin
                next_state.rdata               = 8'h00;
                next_state.rdata[GEN_STS_FLAG] = o_addr_invert_flag_n;
            end else if (i_io_addr == PORT_DRIVE) begin
                next_state.rdata = drive_status;
            end else begin
                next_state.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state.rdata    <= RDATA_RESET;
            state.rd_valid <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign o_io_rdata    = state.rdata;
    assign o_io_rd_valid = state.rd_valid;

    ////////////////////////////////////////////////////////////////////////////
    // Sequences
    sequence s_gen_write;
        i_io_wr && (i_io_addr == PORT_GEN_CLR || i_io_addr == PORT_GEN_SET);
    endsequence

    sequence s_set_write;
        i_io_wr && i_io_addr == PORT_GEN_SET && !i_cpu_reset;
    endsequence

    sequence s_clr_write;
        i_io_wr && i_io_addr == PORT_GEN_CLR;
    endsequence

    sequence s_drive_write;
        i_io_wr && i_io_addr == PORT_DRIVE;
    endsequence

    sequence s_drive_read;
        i_io_rd && i_io_addr == PORT_DRIVE;
    endsequence

    sequence s_flag_read;
        i_io_rd && i_io_addr == PORT_GEN_SET;
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the general control register
    property p_gen_capture;
        @(posedge i_clk) disable iff (i_rst)
        s_gen_write |=> {o_diag_led_bit2_n, o_diag_led_bit1_n, o_diag_led_bit0_n}
                        == $past(i_io_wdata[GEN_LED_MSB:GEN_LED_LSB]);
    endproperty
    a_gen_capture: assert property (p_gen_capture)
        else $error("LED code not captured from general control write");

    property p_reserved_ignored;
        @(posedge i_clk) disable iff (i_rst)
        (s_gen_write ##1 (s_gen_write and ($stable(i_io_wdata[7:4]) && $stable(i_io_addr[0])
                          && !i_cpu_reset && !$past(i_cpu_reset))))
        |=> $stable({led_n, o_addr_invert_flag_n});
    endproperty
    a_reserved_ignored: assert property (p_reserved_ignored)
        else $error("Low nibble of general control changed its outputs");

    property p_flag_set;
        @(posedge i_clk) disable iff (i_rst)
        s_set_write |=> o_addr_invert_flag_n;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("Write to set port did not raise the flag");

    property p_flag_clr;
        @(posedge i_clk) disable iff (i_rst)
        s_clr_write |=> !o_addr_invert_flag_n;
    endproperty
    a_flag_clr: assert property (p_flag_clr)
        else $error("Write to clear port did not lower the flag");

    property p_flag_data_free;
        @(posedge i_clk) disable iff (i_rst)
        (!(i_io_wr && (i_io_addr == PORT_GEN_CLR || i_io_addr == PORT_GEN_SET))
         && !i_cpu_reset) |=> $stable(o_addr_invert_flag_n);
    endproperty
    a_flag_data_free: assert property (p_flag_data_free)
        else $error("Flag moved without a general control write");

    property p_a15_invert;
        @(posedge i_clk) disable iff (i_rst)
        o_mem_a15 == (o_addr_invert_flag_n ? i_cpu_a15 : !i_cpu_a15);
    endproperty
    a_a15_invert: assert property (p_a15_invert)
        else $error("Address line 15 inversion does not follow the flag");

    property p_cpu_reset;
        @(posedge i_clk) disable iff (i_rst)
        i_cpu_reset [*2] |=> !o_addr_invert_flag_n [*1];
    endproperty
    a_cpu_reset: assert property (p_cpu_reset)
        else $error("Flag not held low during processor reset");

    property p_cpu_reset_beats_set;
        @(posedge i_clk) disable iff (i_rst)
        (i_cpu_reset && i_io_wr && i_io_addr == PORT_GEN_SET) |=> !o_addr_invert_flag_n;
    endproperty
    a_cpu_reset_beats_set: assert property (p_cpu_reset_beats_set)
        else $error("Set write overrode processor reset");

    property p_flag_read;
        @(posedge i_clk) disable iff (i_rst)
        s_flag_read |=> o_io_rd_valid && o_io_rdata == {7'h00, $past(o_addr_invert_flag_n)};
    endproperty
    a_flag_read: assert property (p_flag_read)
        else $error("Flag read back wrong on port 21H");

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the drive status register
    property p_status_select;
        @(posedge i_clk) disable iff (i_rst)
        s_drive_read |=> o_io_rd_valid
                         && o_io_rdata[STS_SEL_MSB:STS_SEL_LSB] == $past(o_drive_select);
    endproperty
    a_status_select: assert property (p_status_select)
        else $error("Drive select not echoed in drive status");

    property p_status_live;
        @(posedge i_clk) disable iff (i_rst)
        s_drive_read |=> o_io_rdata[STS_INNER_BIT] == $past(i_inner_track_n)
                         && o_io_rdata[STS_IRQ_BIT] == $past(i_fc_irq)
                         && o_io_rdata[STS_DRQ_BIT] == $past(i_fc_drq);
    endproperty
    a_status_live: assert property (p_status_live)
        else $error("Live floppy chip lines not mirrored in drive status");

    property p_status_motor_side;
        @(posedge i_clk) disable iff (i_rst)
        (s_drive_write ##1 s_drive_read)
        |=> o_io_rdata[STS_MOTOR0_BIT] == !$past(i_io_wdata[DRV_MOTOR0_BIT], 2)
            && o_io_rdata[STS_MOTOR1_BIT] == !$past(i_io_wdata[DRV_MOTOR1_BIT], 2)
            && o_io_rdata[STS_SIDE_BIT] == $past(i_io_wdata[DRV_SIDE_BIT], 2);
    endproperty
    a_status_motor_side: assert property (p_status_motor_side)
        else $error("Motor or side status does not follow drive control");

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the drive control register, reset and the read pulse
    property p_drive_capture;
        @(posedge i_clk) disable iff (i_rst)
        s_drive_write |=> o_drive_select == $past(i_io_wdata[DRV_SEL_MSB:DRV_SEL_LSB])
                          && o_force_ready == $past(i_io_wdata[DRV_READY_BIT])
                          && o_motor0_on_n == !$past(i_io_wdata[DRV_MOTOR0_BIT])
                          && o_motor1_on_n == !$past(i_io_wdata[DRV_MOTOR1_BIT])
                          && o_side_sel_n == $past(i_io_wdata[DRV_SIDE_BIT]);
    endproperty
    a_drive_capture: assert property (p_drive_capture)
        else $error("Drive control fields not captured from write");

    property p_drive_hold;
        @(posedge i_clk) disable iff (i_rst)
        !(i_io_wr && i_io_addr == PORT_DRIVE)
        |=> $stable({o_drive_select, o_force_ready, o_motor0_on_n,
                     o_motor1_on_n, o_side_sel_n});
    endproperty
    a_drive_hold: assert property (p_drive_hold)
        else $error("Drive control changed without a write to port 40H");

    property p_one_drive;
        @(posedge i_clk) disable iff (i_rst)
        $onehot(o_drive_sel_onehot) && o_drive_sel_onehot[o_drive_select];
    endproperty
    a_one_drive: assert property (p_one_drive)
        else $error("Not exactly one drive selected");

    property p_precomp;
        @(posedge i_clk) disable iff (i_rst)
        s_drive_write |=> o_precomp_addr == {!i_inner_track_n,
                                             $past(i_io_wdata[DRV_PC_MSB:DRV_PC_LSB])};
    endproperty
    a_precomp: assert property (p_precomp)
        else $error("Precompensation table address wrong");

    property p_drive_reset;
        @(posedge i_clk)
        i_rst |=> o_motor0_on_n && o_motor1_on_n && !o_force_ready
                  && o_drive_select == 2'h0 && !o_addr_invert_flag_n && !o_io_rd_valid;
    endproperty
    a_drive_reset: assert property (p_drive_reset)
        else $error("Reset did not clear drive control");

    property p_read_pulse;
        @(posedge i_clk) disable iff (i_rst)
        (!i_io_rd ##1 i_io_rd ##1 !i_io_rd) |-> (o_io_rd_valid ##1 !o_io_rd_valid);
    endproperty
    a_read_pulse: assert property (p_read_pulse)
        else $error("Read answer is not a single-cycle pulse");

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the read answer and the LED hold
    sequence s_other_read;
        i_io_rd && i_io_addr != PORT_GEN_SET && i_io_addr != PORT_DRIVE;
    endsequence

    sequence s_write_gap_read;
        s_drive_write ##1 !i_io_wr ##1 s_drive_read;
    endsequence

    property p_read_idle;
        @(posedge i_clk) disable iff (i_rst)
        !i_io_rd |=> !o_io_rd_valid;
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("Read answer without a read strobe");

    property p_rdata_hold;
        @(posedge i_clk) disable iff (i_rst)
        !i_io_rd |=> $stable(o_io_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("Read data changed without a read strobe");

    property p_other_read;
        @(posedge i_clk) disable iff (i_rst)
        s_other_read |=> o_io_rd_valid && o_io_rdata == 8'h00;
    endproperty
    a_other_read: assert property (p_other_read)
        else $error("Read of a write-only or unused port returned data");

    property p_led_hold;
        @(posedge i_clk) disable iff (i_rst)
        !(i_io_wr && (i_io_addr == PORT_GEN_CLR || i_io_addr == PORT_GEN_SET))
        |=> $stable(led_n);
    endproperty
    a_led_hold: assert property (p_led_hold)
        else $error("LED code changed without a general control write");

    property p_status_after_gap;
        @(posedge i_clk) disable iff (i_rst)
        s_write_gap_read
        |=> o_io_rdata[STS_SEL_MSB:STS_SEL_LSB]
            == $past(i_io_wdata[DRV_SEL_MSB:DRV_SEL_LSB], 3)
            && o_io_rdata[STS_MOTOR0_BIT] == !$past(i_io_wdata[DRV_MOTOR0_BIT], 3)
            && o_io_rdata[STS_SIDE_BIT] == $past(i_io_wdata[DRV_SIDE_BIT], 3);
    endproperty
    a_status_after_gap: assert property (p_status_after_gap)
        else $error("Drive status does not echo the last drive control write");

endmodule : aux_cpu_diag_and_drive_regs
`default_nettype wire

// ===== aux_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module aux_cpu_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rd_valid,
    output logic      [7:0] o_addr,
    output logic            o_wr,
    output logic            o_rd,
    output logic      [7:0] o_wdata
);
    logic [7:0] rd_byte;
    logic       rd_ok;
    initial begin
        o_addr  = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_wdata = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////
    // One-cycle strobes, two-cycle write in io_write_pair; released lines show the inverse
    task automatic io_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_addr  = a;
        o_wdata = d;
        o_wr    = 1'b1;
        @(negedge i_clk);
        o_wr    = 1'b0;
        o_addr  = ~a;
        o_wdata = ~d;
    endtask : io_write
    task automatic io_read(input logic [7:0] a);
        @(negedge i_clk);
        o_addr = a;
        o_rd   = 1'b1;
        @(negedge i_clk);
        o_rd    = 1'b0;
        rd_byte = i_rdata;
        rd_ok   = i_rd_valid;
        o_addr  = ~a;
    endtask : io_read
    task automatic io_write_pair(input logic [7:0] a, input logic [7:0] d0,
                                 input logic [7:0] d1);
        @(negedge i_clk);
        o_addr  = a;
        o_wdata = d0;
        o_wr    = 1'b1;
        @(negedge i_clk);
        o_wdata = d1;
        @(negedge i_clk);
        o_wr    = 1'b0;
        o_addr  = ~a;
        o_wdata = ~d1;
    endtask : io_write_pair
    task automatic io_write_read(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_addr  = a;
        o_wdata = d;
        o_wr    = 1'b1;
        @(negedge i_clk);
        o_wr    = 1'b0;
        o_wdata = ~d;
        o_rd    = 1'b1;
        @(negedge i_clk);
        o_rd    = 1'b0;
        rd_byte = i_rdata;
        rd_ok   = i_rd_valid;
        o_addr  = ~a;
    endtask : io_write_read
endmodule : aux_cpu_model
`default_nettype wire

// ===== tb_aux_cpu_diag_and_drive_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_aux_cpu_diag_and_drive_regs;
    import aux_diag_pkg::*;
    logic       i_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic       cpu_rst = 1'b0;
    logic       a15 = 1'b0;
    logic       inner_n = 1'b1;
    logic       irq = 1'b0;
    logic       drq = 1'b0;
    wire  [7:0] addr;
    wire  [7:0] wdata;
    wire        wr;
    wire        rd;
    logic [7:0] rdata;
    logic       rdv, mem_a15, flag_n, led0, led1, led2, rdy, m0n, m1n, side_n;
    logic [1:0] sel;
    logic [3:0] oh;
    logic [2:0] pca;
    int         n_mismatch = 0;
    int         tests_run = 0;
    int         cyc = 0;
    logic [7:0] tbl [4] = '{8'hC4, 8'h19, 8'h6A, 8'hB7};
    always #25 i_clk = ~i_clk;
    aux_cpu_model cpu_u (.i_clk(i_clk), .i_rdata(rdata), .i_rd_valid(rdv), .o_addr(addr),
        .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
    aux_cpu_diag_and_drive_regs dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_cpu_reset(cpu_rst),
        .i_io_addr(addr), .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wdata),
        .o_io_rdata(rdata), .o_io_rd_valid(rdv), .i_cpu_a15(a15), .o_mem_a15(mem_a15),
        .o_addr_invert_flag_n(flag_n), .o_diag_led_bit0_n(led0), .o_diag_led_bit1_n(led1),
        .o_diag_led_bit2_n(led2), .i_inner_track_n(inner_n), .i_fc_irq(irq), .i_fc_drq(drq),
        .o_drive_select(sel), .o_drive_sel_onehot(oh), .o_force_ready(rdy),
        .o_motor0_on_n(m0n), .o_motor1_on_n(m1n), .o_side_sel_n(side_n),
        .o_precomp_addr(pca));
    ////////////////////////////////////////////////////////////////////////////
    // Compare and access helpers
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic gen(input logic f, input logic [2:0] led);
        chk("flag_n", f, flag_n);
        chk("leds", led, {led2, led1, led0});
        repeat (2) begin
            @(negedge i_clk);
            a15 = ~a15;
            #1 chk("mem_a15", {f ? a15 : ~a15}, mem_a15);
        end
    endtask : gen
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        cpu_u.io_read(a);
        chk("rd_valid", 8'h01, cpu_u.rd_ok);
        chk("rdata", e, cpu_u.rd_byte);
    endtask : rdchk
    task automatic drv(input logic [7:0] d);
        chk("sel", d[1:0], sel);
        chk("onehot", 8'h01 << d[1:0], oh);
        chk("ready", d[2], rdy);
        chk("motors_n", {~d[4], ~d[3]}, {m1n, m0n});
        chk("side_n", d[5], side_n);
        chk("precomp", {~inner_n, d[7:6]}, pca);
    endtask : drv
    task automatic final_report();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        gen(GEN_FLAG_RESET, GEN_LED_RESET);
        drv(DRV_CTRL_RESET);
        cpu_u.io_write(8'h21, 8'h2F);
        gen(1'b1, 3'h2);
        rdchk(8'h21, 8'h01);
        cpu_u.io_write(8'h20, 8'hD5);
        gen(1'b0, 3'h5);
        rdchk(8'h21, 8'h00);
        cpu_u.io_write(8'h30, 8'h0F);
        gen(1'b0, 3'h5);
        rdchk(8'h20, 8'h00);
        cpu_u.io_write_pair(8'h21, 8'h7F, 8'h70);
        gen(1'b1, 3'h7);
        cpu_rst = 1'b1;
        cpu_u.io_write(8'h21, 8'h0F);
        gen(1'b0, 3'h0);
        cpu_rst = 1'b0;
        foreach (tbl[i]) begin
            inner_n = i[0];
            irq = i[1];
            drq = ~i[0];
            cpu_u.io_write(8'h40, tbl[i]);
            drv(tbl[i]);
            rdchk(8'h40, {drq, irq, tbl[i][5], ~tbl[i][4:3], inner_n, tbl[i][1:0]});
        end
        cpu_u.io_write_read(8'h40, 8'h38);
        chk("rd_valid", 8'h01, cpu_u.rd_ok);
        chk("rdata", {drq, irq, 3'h4, inner_n, 2'h0}, cpu_u.rd_byte);
        drv(8'h38);
        cpu_u.io_write(8'h41, 8'h00);
        drv(8'h38);
        rdchk(8'h41, 8'h00);
        i_rst = 1'b1;
        repeat (2) @(negedge i_clk);
        i_rst = 1'b0;
        gen(GEN_FLAG_RESET, GEN_LED_RESET);
        drv(DRV_CTRL_RESET);
        final_report();
    end
endmodule : tb_aux_cpu_diag_and_drive_regs
`default_nettype wire
